// file: dcf_fifo.sv
// Summary of operation
// [RULE_01] Full flag releases only after a read edge older than skew1 margin.
// [RULE_02] Almost-empty changes only on write edges older than skew2 margin.
// [RULE_03] Almost-full changes only on read edges older than skew2 margin.
// [RULE_04] Reset works while both sampled clocks keep toggling.
// [RULE_05] After reset outputs are zero when enabled, released when disabled.
// [RULE_06] First stored word appears on the read edge after empty flag rises.
// [RULE_07] Extra first-word latency only arises when writing into an empty FIFO.
// [RULE_08] Almost-empty goes low with empty offset minus one words or fewer.
// [RULE_09] Flags are marked invalid until retransmit recovery time has passed.
// [RULE_10] Partial flags refresh on their next own edge after recovery.
// [RULE_11] Retransmit pulses shorter than the minimum width are ignored.
// [RULE_12] Empty and full offsets reset to seven words.
// [RULE_13] Empty and full flags track occupancy, each on its own edge.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
module dcf_fifo import dcf_pkg::*; #(
   parameter int DEPTH = DCF_DEPTH,
   parameter int WIDTH = DCF_WIDTH
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wclk_pin,
   input wire logic rclk_pin,
   input wire logic write_en_n,
   input wire logic read_en_n,
   input wire logic [WIDTH-1:0] data_in,
   input wire logic master_reset_n,
   input wire logic retransmit_n,
   input wire logic out_en_n,
   output logic [WIDTH-1:0] data_out,
   output logic data_oe,
   output logic empty_flag_n,
   output logic full_flag_n,
   output logic almost_empty_flag_n,
   output logic almost_full_flag_n,
   output logic flags_valid,
   output logic irq,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1;
   localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
   localparam logic [PW-1:0] ONE_P = PW'(1);
   localparam logic [AW-1:0] OFS_RST = AW'(DCF_OFS_DEFAULT);
   localparam logic [7:0] PRT_CYC = 8'(DCF_PRT_CYC);
   localparam logic [7:0] RTR_CYC = 8'(DCF_RTR_CYC);

   // ---------------------------------------------
   // Pin sampling
   // ---------------------------------------------
   localparam int SW = WIDTH + 7;
   logic [SW-1:0] pins_lvl;
   logic [SW-1:0] pins_rise;
   logic [SW-1:0] pins_fall;
   logic w_edge;
   logic r_edge;
   logic wen_s;
   logic ren_s;
   logic mrs_s;
   logic rt_s;
   logic rt_fall;
   logic rt_rise;
   logic oe_n_s;
   logic [WIDTH-1:0] din_s;

   // Pins pass two flops; clocks become one-cycle edge strobes
   dcf_pin_sync #(.W(SW)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin({data_in, out_en_n, retransmit_n, master_reset_n, read_en_n, write_en_n,
            rclk_pin, wclk_pin}),
      .level(pins_lvl),
      .rise(pins_rise),
      .fall(pins_fall)
   );
   assign w_edge = pins_rise[0];
   assign r_edge = pins_rise[1];
   assign wen_s = ~pins_lvl[2];
   assign ren_s = ~pins_lvl[3];
   assign mrs_s = ~pins_lvl[4];
   assign rt_s = ~pins_lvl[5];
   assign rt_fall = pins_fall[5];
   assign rt_rise = pins_rise[5];
   assign oe_n_s = pins_lvl[6];
   assign din_s = pins_lvl[SW-1:7];

   // ---------------------------------------------
   // Storage and pointers
   // ---------------------------------------------
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW-1:0] rd_ptr_s1;
   logic [PW-1:0] rd_ptr_s2;
   logic [PW-1:0] wr_ptr_s1;
   logic [PW-1:0] wr_ptr_s2;
   logic do_write;
   logic do_read;
   logic rt_fire;
   logic in_reset;
   logic [PW-1:0] next_wr_ptr;
   logic [PW-1:0] next_rd_ptr;
   logic [PW-1:0] w_count;
   logic [PW-1:0] w_count2;
   logic [PW-1:0] r_count;
   logic [PW-1:0] r_count2;
   logic [AW-1:0] empty_ofs;
   logic [AW-1:0] full_ofs;

   // Clocks may run through reset; only the sampled reset level matters
   assign in_reset = !aresetn || mrs_s; // [RULE_04]
   assign do_write = w_edge && wen_s && full_flag_n;
   // Read only once the empty flag was already high before this edge
   assign do_read = r_edge && ren_s && empty_flag_n; // [RULE_06] [RULE_07]
   assign next_wr_ptr = do_write ? wr_ptr + ONE_P : wr_ptr;
   assign next_rd_ptr = rt_fire ? '0 : (do_read ? rd_ptr + ONE_P : rd_ptr);

   always_ff @(posedge aclk) begin
      if (do_write) begin
         mem[wr_ptr[AW-1:0]] <= din_s;
      end
   end

   always_ff @(posedge aclk) begin
      if (in_reset) begin
         wr_ptr <= '0;
      end else if (w_edge) begin
         wr_ptr <= next_wr_ptr;
      end
   end

   always_ff @(posedge aclk) begin
      if (in_reset) begin
         rd_ptr <= '0;
      end else if (r_edge || rt_fire) begin
         rd_ptr <= next_rd_ptr;
      end
   end

   // Opposite-side pointers become visible only after the skew margins
   dcf_ptr_delay #(.W(PW), .STAGES(DCF_SKEW1_CYC)) u_rd_s1 (
      .aclk(aclk), .aresetn(!in_reset), .d(rd_ptr), .q(rd_ptr_s1)
   ); // [RULE_01]
   dcf_ptr_delay #(.W(PW), .STAGES(DCF_SKEW2_CYC)) u_rd_s2 (
      .aclk(aclk), .aresetn(!in_reset), .d(rd_ptr), .q(rd_ptr_s2)
   ); // [RULE_03]
   dcf_ptr_delay #(.W(PW), .STAGES(DCF_SKEW1_CYC)) u_wr_s1 (
      .aclk(aclk), .aresetn(!in_reset), .d(wr_ptr), .q(wr_ptr_s1)
   );
   dcf_ptr_delay #(.W(PW), .STAGES(DCF_SKEW2_CYC)) u_wr_s2 (
      .aclk(aclk), .aresetn(!in_reset), .d(wr_ptr), .q(wr_ptr_s2)
   ); // [RULE_02]

   assign w_count = next_wr_ptr - rd_ptr_s1;
   assign w_count2 = next_wr_ptr - rd_ptr_s2;
   assign r_count = wr_ptr_s1 - next_rd_ptr;
   assign r_count2 = wr_ptr_s2 - next_rd_ptr;

   // ---------------------------------------------
   // Flags, each refreshed on its own side's edge
   // ---------------------------------------------
   always_ff @(posedge aclk) begin
      if (in_reset) begin
         full_flag_n <= 1'b1;
         almost_full_flag_n <= 1'b1;
      end else if (w_edge) begin
         full_flag_n <= (w_count != DEPTH_P); // [RULE_13] [RULE_01]
         // Low once Full-(m-1) words or more are stored
         almost_full_flag_n <= (w_count2 + PW'(full_ofs) <= DEPTH_P); // [RULE_03] [RULE_10]
      end
   end

   always_ff @(posedge aclk) begin
      if (in_reset) begin
         empty_flag_n <= 1'b0;
         almost_empty_flag_n <= 1'b0;
      end else if (r_edge || rt_fire) begin
         empty_flag_n <= (r_count != '0); // [RULE_13]
         almost_empty_flag_n <= (r_count2 >= PW'(empty_ofs)); // [RULE_08] [RULE_02] [RULE_10]
      end
   end

   // Output word loads on the read edge; zero from reset
   always_ff @(posedge aclk) begin
      if (in_reset) begin
         data_out <= '0; // [RULE_05]
      end else if (do_read) begin
         data_out <= mem[rd_ptr[AW-1:0]]; // [RULE_06]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_oe <= 1'b0;
      end else begin
         data_oe <= !oe_n_s; // [RULE_05]
      end
   end

   // ---------------------------------------------
   // Retransmit and recovery
   // ---------------------------------------------
   dcf_rt_state_t rt_state;
   logic [7:0] rt_cnt;

   // Action happens at pulse release so a short glitch cannot rewind reads
   assign rt_fire = (rt_state == DCF_RT_PULSE) && rt_rise && (rt_cnt >= PRT_CYC); // [RULE_11]

   always_ff @(posedge aclk) begin
      if (in_reset) begin
         rt_state <= DCF_RT_IDLE;
         rt_cnt <= '0;
      end else begin
         case (rt_state)
            DCF_RT_IDLE: begin
               rt_cnt <= '0;
               if (rt_fall) begin
                  rt_state <= DCF_RT_PULSE;
                  rt_cnt <= 8'h01;
               end
            end
            DCF_RT_PULSE: begin
               if (rt_s && rt_cnt != 8'hFF) begin
                  rt_cnt <= rt_cnt + 8'h01;
               end
               if (rt_fire) begin
                  rt_state <= DCF_RT_RECOVER; // [RULE_09]
                  rt_cnt <= '0;
               end else if (rt_rise) begin
                  rt_state <= DCF_RT_IDLE; // [RULE_11]
               end
            end
            DCF_RT_RECOVER: begin
               rt_cnt <= rt_cnt + 8'h01;
               if (rt_cnt + 8'h01 >= RTR_CYC) begin
                  rt_state <= DCF_RT_IDLE;
               end
            end
            default: rt_state <= DCF_RT_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (in_reset) begin
         flags_valid <= 1'b1;
      end else begin
         flags_valid <= (rt_state == DCF_RT_IDLE) && !rt_fall; // [RULE_09]
      end
   end

   // ---------------------------------------------
   // Interrupt events
   // ---------------------------------------------
   logic [DCF_IRQ_W-1:0] irq_status;
   logic [DCF_IRQ_W-1:0] irq_enable;
   logic [DCF_IRQ_W-1:0] irq_clear;
   logic [DCF_IRQ_W-1:0] irq_event;
   logic flags_prev_e;
   logic flags_prev_f;
   logic flags_prev_ae;
   logic flags_prev_af;
   logic rt_prev;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_prev_e <= 1'b0;
         flags_prev_f <= 1'b1;
         flags_prev_ae <= 1'b0;
         flags_prev_af <= 1'b1;
         rt_prev <= 1'b0;
      end else begin
         flags_prev_e <= empty_flag_n;
         flags_prev_f <= full_flag_n;
         flags_prev_ae <= almost_empty_flag_n;
         flags_prev_af <= almost_full_flag_n;
         rt_prev <= (rt_state == DCF_RT_RECOVER);
      end
   end

   always_comb begin
      irq_event = '0;
      irq_event[DCF_EV_EMPTY] = flags_prev_e && !empty_flag_n;
      irq_event[DCF_EV_FULL] = flags_prev_f && !full_flag_n;
      irq_event[DCF_EV_AEMPTY] = flags_prev_ae && !almost_empty_flag_n;
      irq_event[DCF_EV_AFULL] = flags_prev_af && !almost_full_flag_n;
      irq_event[DCF_EV_RTR_DONE] = rt_prev && (rt_state != DCF_RT_RECOVER);
   end

   // A new event beats a simultaneous clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= '0;
      end else begin
         irq_status <= (irq_status & ~irq_clear) | irq_event;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_enable);
      end
   end

   // ---------------------------------------------
   // AXI4-Lite slave
   // ---------------------------------------------
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_go;
   logic wr_hit;

   assign wr_go = aw_held && w_held && !s_axi_bvalid;
   assign wr_hit = aw_addr == DCF_REG_EMPTY_OFS || aw_addr == DCF_REG_FULL_OFS ||
                   aw_addr == DCF_REG_IRQ_CLEAR || aw_addr == DCF_REG_IRQ_ENABLE;
   assign irq_clear = (wr_go && aw_addr == DCF_REG_IRQ_CLEAR && w_strb[0]) ?
                      w_data[DCF_IRQ_W-1:0] : '0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= DCF_RESP_OKAY;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end else begin
         // Each ready closes when its channel is taken and reopens once the write response is accepted
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
            aw_addr <= {s_axi_awaddr[7:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? DCF_RESP_OKAY : DCF_RESP_DECERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Only byte lane 0 enables a register write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         empty_ofs <= OFS_RST; // [RULE_12]
         full_ofs <= OFS_RST; // [RULE_12]
         irq_enable <= '0;
      end else if (wr_go) begin
         if (aw_addr == DCF_REG_EMPTY_OFS && w_strb[0]) begin
            empty_ofs <= w_data[AW-1:0];
         end
         if (aw_addr == DCF_REG_FULL_OFS && w_strb[0]) begin
            full_ofs <= w_data[AW-1:0];
         end
         if (aw_addr == DCF_REG_IRQ_ENABLE && w_strb[0]) begin
            irq_enable <= w_data[DCF_IRQ_W-1:0];
         end
      end
   end

   logic [31:0] rd_mux;
   logic rd_hit;

   always_comb begin
      rd_mux = '0;
      rd_hit = 1'b1;
      case ({s_axi_araddr[7:2], 2'h0})
         DCF_REG_STATUS: begin
            rd_mux[DCF_ST_EMPTY_N] = empty_flag_n;
            rd_mux[DCF_ST_FULL_N] = full_flag_n;
            rd_mux[DCF_ST_AEMPTY_N] = almost_empty_flag_n;
            rd_mux[DCF_ST_AFULL_N] = almost_full_flag_n;
            rd_mux[DCF_ST_VALID] = flags_valid;
         end
         DCF_REG_LEVEL: rd_mux[PW-1:0] = wr_ptr - rd_ptr;
         DCF_REG_EMPTY_OFS: rd_mux[AW-1:0] = empty_ofs;
         DCF_REG_FULL_OFS: rd_mux[AW-1:0] = full_ofs;
         DCF_REG_IRQ_STATUS: rd_mux[DCF_IRQ_W-1:0] = irq_status;
         DCF_REG_IRQ_CLEAR: rd_mux = '0;
         DCF_REG_IRQ_ENABLE: rd_mux[DCF_IRQ_W-1:0] = irq_enable;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
         s_axi_rdata <= '0;
         s_axi_rresp <= DCF_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_arready <= 1'b0;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_hit ? DCF_RESP_OKAY : DCF_RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule

// file: dcf_fifo_props.sv
module dcf_fifo_props import dcf_pkg::*; #(
   parameter int WIDTH = DCF_WIDTH
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wclk_pin,
   input wire logic rclk_pin,
   input wire logic master_reset_n,
   input wire logic retransmit_n,
   input wire logic out_en_n,
   input wire logic [WIDTH-1:0] data_out,
   input wire logic data_oe,
   input wire logic empty_flag_n,
   input wire logic full_flag_n,
   input wire logic almost_empty_flag_n,
   input wire logic almost_full_flag_n,
   input wire logic flags_valid
);
   // ------------------------------
   // Helper logic
   // ------------------------------
   logic [3:0] age, calm;
   logic r_prev, w_prev, quiet;
   logic [2:0] r_age, w_age;
   always_ff @(posedge aclk) begin
      if (!aresetn) age <= 4'h0;
      else if (age != 4'hF) age <= age + 4'h1;
   end
   // Edge timing is judged away from resets and retransmit
   always_ff @(posedge aclk) begin
      if (!aresetn || !master_reset_n || !retransmit_n || !flags_valid) calm <= 4'h0;
      else if (calm != 4'hF) calm <= calm + 4'h1;
   end
   always_ff @(posedge aclk) begin
      r_prev <= rclk_pin;
      w_prev <= wclk_pin;
      r_age <= (rclk_pin && !r_prev) ? 3'h0 : r_age + {2'h0, r_age != 3'h7};
      w_age <= (wclk_pin && !w_prev) ? 3'h0 : w_age + {2'h0, w_age != 3'h7};
   end
   assign quiet = calm >= 4'hC;
   // ------------------------------
   // Properties
   // ------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_oe_delay: assert property (age > 4'h4 |-> data_oe == !$past(out_en_n, 3))
      else $error("oe does not follow pin");
   a_mreset_state: assert property (!master_reset_n [*6] |->
      data_out == '0 && !empty_flag_n && full_flag_n && !almost_empty_flag_n && almost_full_flag_n)
      else $error("master reset state");
   a_empty_rclk: assert property (quiet && $changed(empty_flag_n) |-> r_age inside {[1:6]})
      else $error("empty off read edge");
   a_full_wclk: assert property (quiet && $changed(full_flag_n) |-> w_age inside {[1:6]})
      else $error("full off write edge");
   a_aempty_rclk: assert property (quiet && $changed(almost_empty_flag_n) |-> r_age inside {[1:6]})
      else $error("almost empty off read edge");
   a_afull_wclk: assert property (quiet && $changed(almost_full_flag_n) |-> w_age inside {[1:6]})
      else $error("almost full off write edge");
   a_data_rclk: assert property (quiet && $changed(data_out) |-> r_age inside {[1:6]})
      else $error("word off read edge");
   a_aempty_order: assert property (!empty_flag_n |-> !almost_empty_flag_n)
      else $error("empty without almost empty");
   a_rtr_window: assert property (!retransmit_n [*4] ##1 retransmit_n |->
      !flags_valid [*4] ##[1:12] flags_valid)
      else $error("retransmit valid window");
   c_full: cover property (!full_flag_n);
   c_rtr: cover property ($rose(flags_valid));
   c_aempty: cover property ($rose(almost_empty_flag_n));
endmodule
bind dcf_fifo dcf_fifo_props #(.WIDTH(WIDTH)) u_props (.*);

// file: dcf_pin_agent.sv
module dcf_pin_agent import dcf_pkg::*; (
   input wire logic aclk,
   input wire logic wr_go,
   input wire logic rd_go,
   input wire logic [DCF_WIDTH-1:0] wr_word,
   output logic wclk_pin,
   output logic rclk_pin,
   output logic write_en_n,
   output logic read_en_n,
   output logic [DCF_WIDTH-1:0] data_in,
   output logic agent_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] ph = 3'h0;
   logic [1:0] ws = 2'h0, rs = 2'h0;
   initial begin
      {wclk_pin, rclk_pin, write_en_n, read_en_n} = 4'h3;
      data_in = '0;
   end
   // Clocks run free, reset included; write edge sits 2 aclk after the read edge
   always @(posedge aclk) begin
      ph <= ph + 3'h1;
      wclk_pin <= (ph == 3'h7) || (ph < 3'h3);
      rclk_pin <= (ph >= 3'h5) || (ph == 3'h0);
   end
   // Enables and data change at the falling pin edge, far from the sampling edge
   always @(posedge aclk) begin
      if (ws == 2'h0 && wr_go) ws <= 2'h1;
      if (ph == 3'h3 && ws == 2'h1) begin
         write_en_n <= 1'b0;
         data_in <= wr_word;
         ws <= 2'h2;
      end
      if (ph == 3'h3 && ws == 2'h2) begin
         write_en_n <= 1'b1;
         data_in <= ~data_in;
         ws <= 2'h0;
      end
   end
   always @(posedge aclk) begin
      if (rs == 2'h0 && rd_go) rs <= 2'h1;
      if (ph == 3'h1 && rs == 2'h1) begin
         read_en_n <= 1'b0;
         rs <= 2'h2;
      end
      if (ph == 3'h1 && rs == 2'h2) begin
         read_en_n <= 1'b1;
         rs <= 2'h0;
      end
   end
   assign agent_busy = (ws != 2'h0) || (rs != 2'h0);
endmodule

// file: dcf_pin_sync.sv
module dcf_pin_sync import dcf_pkg::*; #(
   parameter int W = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   logic [W-1:0] meta;
   logic [W-1:0] prev;

   // Only the second stage and later are looked at
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= '0;
         level <= '0;
         prev <= '0;
      end else begin
         meta <= pin;
         level <= meta;
         prev <= level;
      end
   end

   assign rise = level & ~prev;
   assign fall = ~level & prev;
endmodule

// file: dcf_pkg.sv
package dcf_pkg;
   // ---------------------------------------------
   // Geometry and timing
   // ---------------------------------------------
   localparam int DCF_DEPTH = 65536;
   localparam int DCF_WIDTH = 9;
   localparam int DCF_CLK_NS = 20;
   localparam int DCF_SKEW1_NS = 5;
   localparam int DCF_SKEW2_NS = 10;
   localparam int DCF_PRT_NS = 60;
   localparam int DCF_RTR_NS = 90;
   localparam int DCF_SKEW1_CYC = (DCF_SKEW1_NS + DCF_CLK_NS - 1) / DCF_CLK_NS;
   localparam int DCF_SKEW2_CYC = (DCF_SKEW2_NS + DCF_CLK_NS - 1) / DCF_CLK_NS;
   localparam int DCF_PRT_CYC = (DCF_PRT_NS + DCF_CLK_NS - 1) / DCF_CLK_NS;
   localparam int DCF_RTR_CYC = (DCF_RTR_NS + DCF_CLK_NS - 1) / DCF_CLK_NS;
   localparam int DCF_OFS_DEFAULT = 7;
   // ---------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------
   localparam logic [7:0] DCF_REG_STATUS = 8'h00;
   localparam logic [7:0] DCF_REG_LEVEL = 8'h04;
   localparam logic [7:0] DCF_REG_EMPTY_OFS = 8'h08;
   localparam logic [7:0] DCF_REG_FULL_OFS = 8'h0C;
   localparam logic [7:0] DCF_REG_IRQ_STATUS = 8'h10;
   localparam logic [7:0] DCF_REG_IRQ_CLEAR = 8'h14;
   localparam logic [7:0] DCF_REG_IRQ_ENABLE = 8'h18;
   localparam logic [1:0] DCF_RESP_OKAY = 2'h0;
   localparam logic [1:0] DCF_RESP_DECERR = 2'h3;
   // Status bit positions
   localparam int DCF_ST_EMPTY_N = 0;
   localparam int DCF_ST_FULL_N = 1;
   localparam int DCF_ST_AEMPTY_N = 2;
   localparam int DCF_ST_AFULL_N = 3;
   localparam int DCF_ST_VALID = 4;
   // Interrupt event bits
   localparam int DCF_IRQ_W = 5;
   localparam int DCF_EV_EMPTY = 0;
   localparam int DCF_EV_FULL = 1;
   localparam int DCF_EV_AEMPTY = 2;
   localparam int DCF_EV_AFULL = 3;
   localparam int DCF_EV_RTR_DONE = 4;
   typedef enum logic [1:0] {
      DCF_RT_IDLE = 2'h0,
      DCF_RT_PULSE = 2'h1,
      DCF_RT_RECOVER = 2'h3
   } dcf_rt_state_t;
endpackage

// file: dcf_ptr_delay.sv
module dcf_ptr_delay import dcf_pkg::*; #(
   parameter int W = 17,
   parameter int STAGES = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] line [0:STAGES];

   assign line[0] = d;
   // One stage per cycle of margin the opposite side must see
   for (genvar i = 0; i < STAGES; i++) begin : g_stage
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            line[i+1] <= '0;
         end else begin
            line[i+1] <= line[i];
         end
      end
   end
   assign q = line[STAGES];
endmodule

// file: test_dual_clock_fifo_flag_timing.sv
module test_dual_clock_fifo_flag_timing import dcf_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int FIFO_DEPTH = 16;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic master_reset_n = 1'b1;
   logic retransmit_n = 1'b1;
   logic out_en_n = 1'b0;
   logic wr_go = 1'b0;
   logic rd_go = 1'b0;
   logic [8:0] wr_word;
   logic wclk_pin, rclk_pin, write_en_n, read_en_n, agent_busy;
   logic [8:0] data_in, data_out, w;
   logic data_oe, empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n;
   logic flags_valid, irq;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [31:0] s_axi_rdata, rd;
   logic [8:0] q[$];
   int seed;
   int n_errors = 0;
   int num_checks = 0;
   // Depth cut to 16 so full is reached within a short run
   dcf_fifo #(.DEPTH(FIFO_DEPTH), .WIDTH(9)) dut_u (.*);
   dcf_pin_agent agent_u (.*);
   always #10 aclk = ~aclk;
   // ------------------------------
   // Shared tasks
   // ------------------------------
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   task chk_flags(input int c);
      chk("flags", {almost_full_flag_n, almost_empty_flag_n, full_flag_n, empty_flag_n},
         {28'h0, c < FIFO_DEPTH - 6, c >= 7, c != FIFO_DEPTH, c != 0});
   endtask
   task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      r = s_axi_bresp;
   endtask
   task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      {d, r} = {s_axi_rdata, s_axi_rresp};
   endtask
   // One pin transfer, then time for both sides to see it
   task pin_op(input logic wr, input logic [8:0] v);
      @(posedge aclk);
      wr_word <= v;
      wr_go <= wr;
      rd_go <= !wr;
      @(posedge aclk);
      wr_go <= 1'b0;
      rd_go <= 1'b0;
      @(posedge aclk);
      for (int k = 0; k < 40 && agent_busy; k++) @(posedge aclk);
      repeat (24) @(posedge aclk);
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      close_out;
   end
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      seed = 65;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (6) @(posedge aclk);
      chk_flags(0);
      chk("reset data", data_out, 0);
      chk("oe on", data_oe, 1);
      axr(DCF_REG_EMPTY_OFS, rd, rr);
      chk("empty offset", rd[15:0], 7);
      axr(DCF_REG_FULL_OFS, rd, rr);
      chk("full offset", rd[15:0], 7);
      axr(8'h40, rd, rr);
      chk("unmapped read", rr, DCF_RESP_DECERR);
      axw(8'h40, 32'h0000_00FF, rr);
      chk("unmapped write", rr, DCF_RESP_DECERR);
      out_en_n <= 1'b1;
      repeat (5) @(posedge aclk);
      chk("oe off", data_oe, 0);
      axw(DCF_REG_IRQ_ENABLE, 32'h0000_0002, rr);
      $display("test reset finished");
      for (int i = 0; i <= FIFO_DEPTH; i++) begin
         w = 9'($random(seed));
         pin_op(1'b1, w);
         if (q.size() < FIFO_DEPTH) q.push_back(w);
         chk_flags(q.size());
      end
      axr(DCF_REG_LEVEL, rd, rr);
      chk("level", rd[16:0], FIFO_DEPTH);
      chk("irq on full", irq, 1);
      axw(DCF_REG_IRQ_ENABLE, 32'h0000_0000, rr);
      axw(DCF_REG_IRQ_CLEAR, 32'h0000_001F, rr);
      axr(DCF_REG_IRQ_STATUS, rd, rr);
      chk("irq status", rd, 0);
      chk("irq off", irq, 0);
      $display("test fill finished");
      out_en_n <= 1'b0;
      while (q.size() > 0) begin
         pin_op(1'b0, 9'h000);
         w = q.pop_front();
         chk("read word", data_out, w);
         chk_flags(q.size());
      end
      pin_op(1'b0, 9'h000);
      chk("refused read", data_out, w);
      chk("irq masked", irq, 0);
      axw(DCF_REG_IRQ_ENABLE, 32'h0000_0001, rr);
      repeat (3) @(posedge aclk);
      chk("irq unmasked", irq, 1);
      axw(DCF_REG_IRQ_CLEAR, 32'h0000_001F, rr);
      repeat (3) @(posedge aclk);
      chk("irq cleared", irq, 0);
      $display("test drain finished");
      master_reset_n <= 1'b0;
      repeat (8) @(posedge aclk);
      master_reset_n <= 1'b1;
      repeat (8) @(posedge aclk);
      chk_flags(0);
      chk("mreset data", data_out, 0);
      for (int i = 0; i < 3; i++) begin
         w = 9'($random(seed));
         pin_op(1'b1, w);
         q.push_back(w);
      end
      pin_op(1'b0, 9'h000);
      chk("first word", data_out, q[0]);
      retransmit_n <= 1'b0;
      repeat (6) @(posedge aclk);
      retransmit_n <= 1'b1;
      repeat (12) @(posedge aclk);
      chk("flags valid", flags_valid, 1);
      repeat (16) @(posedge aclk);
      chk_flags(3);
      while (q.size() > 0) begin
         pin_op(1'b0, 9'h000);
         chk("replayed word", data_out, q.pop_front());
      end
      chk_flags(0);
      $display("test retransmit finished");
      close_out;
   end
endmodule
